// [pkg/wdtc_pkg.sv]
`default_nettype none
package wdtc_pkg;
    // System clock and watchdog oscillator rates
    localparam int CLK_HZ = 10_000_000;
    localparam int OSC_HZ = 128_000;

    // Control register as seen by the core
    localparam logic [7:0] CTRL_OFFSET = 8'h60;
    localparam int FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int PSEL3_BIT = 5;
    localparam int CHG_EN_BIT = 4;
    localparam int RST_EN_BIT = 3;
    localparam int PSEL2_BIT = 2;
    localparam int PSEL0_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Prescaler: code 0 is 2048 oscillator cycles, doubling up to code 9
    localparam int CNT_W = 21;
    localparam logic [CNT_W-1:0] CYC_BASE = 21'h000800;
    localparam logic [3:0] PSEL_MAX = 4'h9;
    localparam logic [3:0] PSEL_RESET = 4'h0;

    // Protected change window in system clock cycles
    localparam logic [2:0] CHG_WINDOW = 3'h4;

    // Core-side Wishbone registers
    localparam logic [7:0] CMD_OFFSET = 8'h00;
    localparam logic [7:0] CFG_OFFSET = 8'h04;
    localparam logic [7:0] STAT_OFFSET = 8'h08;
    localparam int CMD_RESTART_BIT = 0;
    localparam int CMD_VECTOR_BIT = 1;
    localparam int CMD_CLR_CAUSE_BIT = 2;
    localparam int CFG_GIE_BIT = 0;
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_RST_SEEN_BIT = 1;
    localparam int STAT_CAUSE_BIT = 2;
    localparam int STAT_WAKE_BIT = 3;

    typedef struct packed {
        logic [2:0] osc_sync;
        logic [CNT_W-1:0] count;
        logic flag;
        logic irq_en;
        logic [3:0] psel;
        logic chg_en;
        logic [2:0] chg_cnt;
        logic rst_en;
        logic cause;
        logic sys_rst;
    } wdtc_dev_state_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic wr_stb;
        logic [7:0] wr_data;
        logic restart;
        logic vec_ack;
        logic clr_cause;
        logic gie;
        logic rst_seen;
    } wdtc_core_state_t;
endpackage
`default_nettype wire

// [pkg/wdtc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface wdtc_if;
    logic wr_stb;
    logic [7:0] wr_data;
    logic restart;
    logic vec_ack;
    logic clr_cause;
    logic gie;
    logic [7:0] rd_data;
    logic irq;
    logic wake;
    logic sys_rst;
    logic cause;

    modport device (
        input wr_stb, wr_data, restart, vec_ack, clr_cause, gie,
        output rd_data, irq, wake, sys_rst, cause
    );
    modport core (
        output wr_stb, wr_data, restart, vec_ack, clr_cause, gie,
        input rd_data, irq, wake, sys_rst, cause
    );
endinterface
`default_nettype wire

// [logic/wdtc_device.sv]
// How it works
// - Count ticks of separate 128 KHz oscillator
// - Restart zeroes counter; missed restart fires action
// - Interrupt mode raises interrupt, can wake
// - Reset mode requests system reset on expiry
// - Always-on fuse forces reset mode
// - Opening write sets change and reset enables
// - Protected update accepted only inside window
// - Change enable self-clears after four cycles
// - Reset clear, prescaler change need change enable
// - Flag set on interrupt time-out, cleared by write-one or vector
// - Interrupt needs global enable and enable bit
// - Mode decoded from fuse, clock monitor, cause and enable bits
// - Combined mode: vector clears flag and enable
// - Combined mode: unserviced second time-out resets
// - Clock monitor forces reset, disables interrupt
// - Clock monitor with any enable: reset mode
// - Watchdog stays enabled after its own reset
// - Init software clears cause flag, reset enable
// - Restart before changing the prescaler
// - Cause flag forces reset enable set
// - Prescaler codes map 2048 doubling to 1048576
// - Watchdog reset is one-cycle pulse
// - Watchdog reset sets cause flag
`timescale 1ns/1ps
`default_nettype none
module wdtc_device (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_clk_i,
    input wire logic always_on_fuse_i,
    input wire logic clock_monitor_i,
    wdtc_if.device link
);
    wdtc_pkg::wdtc_dev_state_t s_reg;
    wdtc_pkg::wdtc_dev_state_t s_next;

    logic tick;
    logic fuse;
    logic cmon;
    logic rst_en_eff;
    logic irq_en_eff;
    logic running;
    logic int_only;
    logic combined;
    logic reset_only;
    logic [3:0] psel_eff;
    logic [wdtc_pkg::CNT_W-1:0] limit_m1;
    logic timeout;
    logic fire_reset;
    logic flag_set;
    logic [7:0] d;
    logic [3:0] psel_wr;
    logic past_limit;
    logic [7:0] ctrl_view;

    // Fuse and clock monitor are levels from this clock domain
    assign fuse = always_on_fuse_i;
    assign cmon = clock_monitor_i;

    // Rising edge seen after two flops; third flop only marks the edge
    assign tick = s_reg.osc_sync[1] & ~s_reg.osc_sync[2];

    assign rst_en_eff = s_reg.rst_en | s_reg.cause | fuse;
    assign irq_en_eff = s_reg.irq_en & ~fuse & ~cmon;
    assign running = fuse | rst_en_eff | s_reg.irq_en;
    assign int_only = irq_en_eff & ~rst_en_eff;
    assign combined = irq_en_eff & rst_en_eff;
    assign reset_only = running & ~irq_en_eff;

    // Reserved codes run as the longest period rather than stopping
    assign psel_eff = (s_reg.psel > wdtc_pkg::PSEL_MAX) ? wdtc_pkg::PSEL_MAX : s_reg.psel;
    assign limit_m1 = (wdtc_pkg::CYC_BASE << psel_eff) - 21'h000001;
    assign psel_wr = {link.wr_data[wdtc_pkg::PSEL3_BIT],
        link.wr_data[wdtc_pkg::PSEL2_BIT:wdtc_pkg::PSEL0_BIT]};

    // At or past the limit, so a shorter period expires at once
    assign past_limit = (s_reg.count >= limit_m1);
    // A restart in the tick's own cycle wins over the time-out
    assign timeout = running & tick & ~link.restart & past_limit;

    always_comb begin
        fire_reset = 1'b0;
        flag_set = 1'b0;
        if (timeout) begin
            if (int_only) begin
                flag_set = 1'b1;
            end else if (combined) begin
                if (s_reg.flag) begin
                    fire_reset = 1'b1;
                end else begin
                    flag_set = 1'b1;
                end
            end else if (reset_only) begin
                fire_reset = 1'b1;
            end else begin
                fire_reset = 1'b0;
            end
        end
    end

    always_comb begin
        s_next = s_reg;
        d = link.wr_data;
        s_next.osc_sync = {s_reg.osc_sync[1:0], osc_clk_i};
        s_next.sys_rst = fire_reset;

        if (link.restart || !running) begin
            s_next.count = '0;
        end else if (tick) begin
            if (timeout) begin
                s_next.count = '0;
            end else begin
                s_next.count = s_reg.count + 21'h000001;
            end
        end

        // Window closes by itself four edges after opening
        if (s_reg.chg_cnt != 3'h0) begin
            s_next.chg_cnt = s_reg.chg_cnt - 3'h1;
            if (s_reg.chg_cnt == 3'h1) begin
                s_next.chg_en = 1'b0;
            end
        end

        if (link.vec_ack && s_reg.flag) begin
            s_next.flag = 1'b0;
            if (rst_en_eff) begin
                s_next.irq_en = 1'b0;
            end
        end

        if (link.wr_stb) begin
            if (d[wdtc_pkg::FLAG_BIT]) begin
                s_next.flag = 1'b0;
            end
            s_next.irq_en = d[wdtc_pkg::IRQ_EN_BIT];
            if (d[wdtc_pkg::CHG_EN_BIT] && d[wdtc_pkg::RST_EN_BIT]) begin
                s_next.chg_en = 1'b1;
                s_next.chg_cnt = wdtc_pkg::CHG_WINDOW;
                s_next.rst_en = 1'b1;
            end else if (s_reg.chg_en && !d[wdtc_pkg::CHG_EN_BIT]) begin
                // One protected update per opened window
                s_next.rst_en = d[wdtc_pkg::RST_EN_BIT];
                s_next.psel = psel_wr;
                s_next.chg_en = 1'b0;
                s_next.chg_cnt = 3'h0;
            end else if (d[wdtc_pkg::RST_EN_BIT]) begin
                s_next.rst_en = 1'b1;
            end
        end

        // Set wins over a write-one or vector clear
        if (flag_set) begin
            s_next.flag = 1'b1;
        end

        if (link.clr_cause) begin
            s_next.cause = 1'b0;
        end
        // The pulse sets the cause, winning over a clr_cause in the same cycle
        if (fire_reset) begin
            s_next.cause = 1'b1;
        end

        if (fuse) begin
            s_next.irq_en = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg.osc_sync <= 3'h0;
            s_reg.count <= '0;
            s_reg.flag <= 1'b0;
            s_reg.irq_en <= 1'b0;
            s_reg.psel <= wdtc_pkg::PSEL_RESET;
            s_reg.chg_en <= 1'b0;
            s_reg.chg_cnt <= 3'h0;
            s_reg.rst_en <= 1'b0;
            s_reg.cause <= 1'b0;
            s_reg.sys_rst <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Reset enable reads set under cause or fuse
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[wdtc_pkg::FLAG_BIT] = s_reg.flag;
        ctrl_view[wdtc_pkg::IRQ_EN_BIT] = s_reg.irq_en & ~fuse;
        ctrl_view[wdtc_pkg::PSEL3_BIT] = s_reg.psel[3];
        ctrl_view[wdtc_pkg::CHG_EN_BIT] = s_reg.chg_en;
        ctrl_view[wdtc_pkg::RST_EN_BIT] = rst_en_eff;
        ctrl_view[wdtc_pkg::PSEL2_BIT:wdtc_pkg::PSEL0_BIT] = s_reg.psel[2:0];
    end

    assign link.rd_data = ctrl_view;

    assign link.irq = s_reg.flag & irq_en_eff & link.gie;
    assign link.wake = s_reg.flag & irq_en_eff;
    assign link.sys_rst = s_reg.sys_rst;
    assign link.cause = s_reg.cause;
endmodule
`default_nettype wire

// [logic/wdtc_core.sv]
`timescale 1ns/1ps
`default_nettype none
module wdtc_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    wdtc_if.core link
);
    wdtc_pkg::wdtc_core_state_t s_reg;
    wdtc_pkg::wdtc_core_state_t s_next;
    logic req;
    logic [31:0] status;

    assign req = wb_cyc_i & wb_stb_i & ~s_reg.ack;

    always_comb begin
        status = 32'h00000000;
        status[wdtc_pkg::STAT_IRQ_BIT] = link.irq;
        status[wdtc_pkg::STAT_RST_SEEN_BIT] = s_reg.rst_seen;
        status[wdtc_pkg::STAT_CAUSE_BIT] = link.cause;
        status[wdtc_pkg::STAT_WAKE_BIT] = link.wake;
    end

    always_comb begin
        s_next = s_reg;
        s_next.ack = req;
        s_next.wr_stb = 1'b0;
        s_next.restart = 1'b0;
        s_next.vec_ack = 1'b0;
        s_next.clr_cause = 1'b0;
        if (req) begin
            s_next.dat = 32'h00000000;
            if (wb_we_i) begin
                if (wb_sel_i[0]) begin
                    case (wb_adr_i)
                        wdtc_pkg::CTRL_OFFSET: begin
                            s_next.wr_stb = 1'b1;
                            s_next.wr_data = wb_dat_i[7:0];
                        end
                        wdtc_pkg::CMD_OFFSET: begin
                            s_next.restart = wb_dat_i[wdtc_pkg::CMD_RESTART_BIT];
                            s_next.vec_ack = wb_dat_i[wdtc_pkg::CMD_VECTOR_BIT];
                            s_next.clr_cause = wb_dat_i[wdtc_pkg::CMD_CLR_CAUSE_BIT];
                        end
                        wdtc_pkg::CFG_OFFSET: begin
                            s_next.gie = wb_dat_i[wdtc_pkg::CFG_GIE_BIT];
                        end
                        wdtc_pkg::STAT_OFFSET: begin
                            if (wb_dat_i[wdtc_pkg::STAT_RST_SEEN_BIT]) begin
                                s_next.rst_seen = 1'b0;
                            end
                        end
                        default: begin
                            s_next.wr_stb = 1'b0;
                        end
                    endcase
                end
            end else begin
                case (wb_adr_i)
                    wdtc_pkg::CTRL_OFFSET: s_next.dat = {24'h000000, link.rd_data};
                    wdtc_pkg::CFG_OFFSET: s_next.dat = {31'h00000000, s_reg.gie};
                    wdtc_pkg::STAT_OFFSET: s_next.dat = status;
                    default: s_next.dat = 32'h00000000;
                endcase
            end
        end
        if (link.sys_rst) begin
            s_next.rst_seen = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg.ack <= 1'b0;
            s_reg.dat <= 32'h00000000;
            s_reg.wr_stb <= 1'b0;
            s_reg.wr_data <= wdtc_pkg::CTRL_RESET;
            s_reg.restart <= 1'b0;
            s_reg.vec_ack <= 1'b0;
            s_reg.clr_cause <= 1'b0;
            s_reg.gie <= 1'b0;
            s_reg.rst_seen <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;
    assign link.wr_stb = s_reg.wr_stb;
    assign link.wr_data = s_reg.wr_data;
    assign link.restart = s_reg.restart;
    assign link.vec_ack = s_reg.vec_ack;
    assign link.clr_cause = s_reg.clr_cause;
    assign link.gie = s_reg.gie;
endmodule
`default_nettype wire

// [sim/wdtc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module wdtc_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic always_on_fuse_i,
    input wire logic clock_monitor_i,
    input wire logic vec_ack_i,
    input wire logic clr_cause_i,
    input wire logic gie_i,
    input wire logic [7:0] rd_data_i,
    input wire logic irq_i,
    input wire logic wake_i,
    input wire logic sys_rst_i,
    input wire logic cause_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_pulse;
        sys_rst_i |=> !sys_rst_i;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("reset pulse too long");
    property p_cause;
        sys_rst_i |-> ##[0:1] cause_i;
    endproperty
    a_cause: assert property (p_cause)
        else $error("cause not set");
    property p_hold;
        cause_i |-> rd_data_i[3];
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset enable dropped");
    property p_fuse;
        always_on_fuse_i |-> rd_data_i[3] && !rd_data_i[6];
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("fuse not forcing");
    // Monitor and fuse both mask the request
    property p_irq;
        irq_i == (rd_data_i[7] && rd_data_i[6] && gie_i && !always_on_fuse_i && !clock_monitor_i);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq level wrong");
    property p_wake;
        wake_i == (rd_data_i[7] && rd_data_i[6] && !always_on_fuse_i && !clock_monitor_i);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake level wrong");
    property p_chg;
        $rose(rd_data_i[4]) |-> ##[1:4] !rd_data_i[4];
    endproperty
    a_chg: assert property (p_chg)
        else $error("window too long");
    property p_lock;
        !rd_data_i[4] |=> $stable({rd_data_i[5], rd_data_i[2:0]});
    endproperty
    a_lock: assert property (p_lock)
        else $error("prescaler changed");
    // Cause clear may drop a stored zero
    property p_rsten;
        !rd_data_i[4] && rd_data_i[3] && !always_on_fuse_i && !clr_cause_i |=> rd_data_i[3];
    endproperty
    a_rsten: assert property (p_rsten)
        else $error("reset enable cleared");
    property p_vec;
        vec_ack_i && rd_data_i[7] && rd_data_i[3] |=> !rd_data_i[7] && !rd_data_i[6];
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector clear wrong");
    c_rst: cover property (sys_rst_i);
    c_irq: cover property (irq_i);
    c_chg: cover property ($rose(rd_data_i[4]));
endmodule
`default_nettype wire

// [sim/wdtc_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module wdtc_tb;
    localparam logic [7:0] CT = wdtc_pkg::CTRL_OFFSET;
    localparam logic [7:0] CM = wdtc_pkg::CMD_OFFSET;
    localparam logic [7:0] CF = wdtc_pkg::CFG_OFFSET;
    localparam logic [7:0] ST = wdtc_pkg::STAT_OFFSET;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic osc_clk_i = 1'h0;
    logic fuse = 1'h0;
    logic cm = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o;
    logic [3:0] r;
    logic [3:0] p;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'hDAB453EB;
    int n;
    wdtc_if lk();
    initial forever #50 clk_i = ~clk_i;
    // Not a multiple of the clock, so ticks drift
    initial forever #170 osc_clk_i = ~osc_clk_i;
    wdtc_device wdtc_device_i (.clk_i, .rst_i, .osc_clk_i, .always_on_fuse_i(fuse),
        .clock_monitor_i(cm), .link(lk));
    wdtc_core wdtc_core_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link(lk));
    wdtc_monitor wdtc_monitor_i (.clk_i, .rst_i, .always_on_fuse_i(fuse),
        .clock_monitor_i(cm), .vec_ack_i(lk.vec_ack), .clr_cause_i(lk.clr_cause),
        .gie_i(lk.gie), .rd_data_i(lk.rd_data), .irq_i(lk.irq), .wake_i(lk.wake),
        .sys_rst_i(lk.sys_rst), .cause_i(lk.cause));
    function automatic logic [7:0] cv(input logic ie, input logic [3:0] ps, input logic re);
        return {1'h0, ie, ps[3], 1'h0, re, ps[2:0]};
    endfunction
    task automatic summarize;
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        wb(1'h0, a, 32'h0);
        chk(q & {24'h0, m}, {24'h0, e});
    endtask
    task automatic protect(input logic [3:0] ps, input logic [7:0] e);
        wb(1'h1, CT, 32'h18);
        wb(1'h1, CT, {24'h0, cv(1'h0, ps, 1'h0)});
        rd(CT, 8'hFF, e);
    endtask
    // Restart, then time the event against 2048 ticks of 340 ns
    task automatic wait_ev(input int s);
        wb(1'h1, CM, 32'h1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((s == 0 ? lk.irq : s == 1 ? lk.sys_rst : lk.wake) !== 1'h1 && n < 8000);
        chk({31'h0, n > 6930 && n < 7000}, 32'h1);
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        r = 4'($random(seed));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(CT, 8'hFF, 8'h00);
        wb(1'h1, 8'h40, $random(seed));
        rd(8'h40, 8'hFF, 8'h00);
        wb(1'h1, CT, {24'h0, cv(1'h0, 4'h5, 1'h0)});
        rd(CT, 8'hFF, 8'h00);
        wb(1'h1, CT, 32'h10);
        wb(1'h1, CT, {24'h0, cv(1'h0, 4'h5, 1'h0)});
        rd(CT, 8'hFF, 8'h00);
        for (int i = 0; i < 16; i++) begin
            p = i[3:0] ^ r;
            protect(p, cv(1'h0, p, 1'h0));
        end
        wb(1'h1, CT, 32'h18);
        rd(CT, 8'h10, 8'h10);
        wb(1'h1, CT, {24'h0, cv(1'h0, 4'h3, 1'h0)});
        rd(CT, 8'hFF, cv(1'h0, p, 1'h1));
        wb(1'h1, CM, 32'h1);
        protect(4'h0, 8'h00);
        wb(1'h1, CF, 32'h1);
        rd(CF, 8'hFF, 8'h01);
        wb(1'h1, CT, 32'h40);
        repeat (3) begin
            repeat (2000 + ($random(seed) & 1023)) @(posedge clk_i);
            chk({31'h0, lk.irq}, 32'h0);
            wb(1'h1, CM, 32'h1);
        end
        wait_ev(0);
        rd(CT, 8'hFF, 8'hC0);
        rd(ST, 8'h0F, 8'h09);
        wb(1'h1, CT, 32'hC0);
        rd(CT, 8'hFF, 8'h40);
        wb(1'h1, CF, 32'h0);
        wait_ev(2);
        chk({31'h0, lk.irq}, 32'h0);
        wb(1'h1, CM, 32'h2);
        rd(CT, 8'hFF, 8'h40);
        wb(1'h1, CF, 32'h1);
        wb(1'h1, CT, 32'h48);
        wait_ev(0);
        wb(1'h1, CM, 32'h2);
        rd(CT, 8'hFF, 8'h08);
        wait_ev(1);
        rd(ST, 8'h06, 8'h06);
        wb(1'h1, ST, 32'h2);
        rd(ST, 8'h06, 8'h04);
        wb(1'h1, CT, 32'h48);
        wait_ev(0);
        wait_ev(1);
        wb(1'h1, CT, 32'h80);
        protect(4'h0, 8'h08);
        wb(1'h1, CM, 32'h4);
        protect(4'h0, 8'h00);
        cm <= 1'h1;
        wb(1'h1, CT, 32'h40);
        wait_ev(1);
        cm <= 1'h0;
        fuse <= 1'h1;
        wb(1'h1, CT, 32'h40);
        rd(CT, 8'h48, 8'h08);
        wait_ev(1);
        summarize();
    end
endmodule
`default_nettype wire
